// ==== rtl/vout_target_limit_logic.sv ====
/*
 Output-voltage target logic of a PMBus-managed buck converter: a PMBus slave on sampled
 SCL/SDA, the target registers, clamping, warning status and a slew-limited ramp.
 Assumes SCL and SDA come from pins (synchronised here) and CONV_EN from local logic.
*/
`timescale 1ns/1ns
`default_nettype none
`include "vout_target_map.svh"
module vout_target_limit_logic #(
   parameter logic [6:0] DEV_ADDR = 7'h2a,   // Arbitrary bus address
   parameter logic [12:0] DAC_MAX = 13'h0180,
   parameter logic [15:0] LIMIT_LO = 16'h00af,
   parameter logic [15:0] LIMIT_HI = 16'h0180,
   parameter int STEP_CYC = `STEP_CYCLES
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic CONV_EN,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N,
   output logic ALERT_O,
   output logic ALERT_OE_N,
   output vout_target_pkg::vcode_t TARGET_CODE,
   output vout_target_pkg::vcode_t VOUT_CODE
);
   import vout_target_pkg::*;

   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   link_state_t st_r;
   logic [2:0] bitc_r, nb_r;
   logic [7:0] sh_r, tx_r, cmd_r, lo_r, wadr_r;
   logic [15:0] wdat_r;
   logic rw_r, half_r, drv_r, txhi_r, wr_r, upd_r;
   vcode_t cmd_v_r, tgt_r, out_r;
   logic [6:0] trim_r;
   logic [11:0] umax_r, umin_r;
   logic [10:0] mh_r;
   logic [7:0] op_r;
   logic warn_r, ivd_r, alert_r;
   logic [15:0] cnt_r;

   // Pin synchronisers
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else if (CE) begin
         {scl_m, scl_s, scl_d} <= {SCL_I, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {SDA_I, sda_m, sda_s};
      end
   end

   wire rise = scl_s & ~scl_d;
   wire fall = ~scl_s & scl_d;
   wire start = scl_s & scl_d & sda_d & ~sda_s;
   wire stop = scl_s & scl_d & ~sda_d & sda_s;
   wire ack_ok = (nb_r != 3'h0) | (sh_r[7:1] == DEV_ADDR);
   wire [7:0] wadr_w = (nb_r == 3'h1) ? sh_r : cmd_r;
   wire commit_w = (nb_r == 3'h1 && sh_r == `CMD_CLEAR_FAULTS) ||
      (nb_r == 3'h2 && cmd_r == `CMD_OPERATION) || (nb_r == 3'h3);
   wire [15:0] wdat_w = (nb_r == 3'h3) ? {sh_r, lo_r} : {8'h00, sh_r};

   // Read-back selection
   wire signed [15:0] trim_ext = {{9{trim_r[6]}}, trim_r};
   wire [7:0] sbyte = (8'(warn_r) << `SB_NONE_ABOVE) | (8'(ivd_r) << `SB_CML);
   wire [15:0] rd_word =
      (cmd_r == `CMD_OPERATION) ? {8'h00, op_r} :
      (cmd_r == `CMD_MODE) ? {8'h00, `MODE_VALUE} :
      (cmd_r == `CMD_COMMAND) ? {3'h0, cmd_v_r} :
      (cmd_r == `CMD_TRIM) ? trim_ext :
      (cmd_r == `CMD_UPPER_LIMIT) ? {4'h0, umax_r} :
      (cmd_r == `CMD_MARGIN_HIGH) ? {5'h00, mh_r} :
      (cmd_r == `CMD_LOWER_LIMIT) ? {4'h0, umin_r} :
      (cmd_r == `CMD_STAT_BYTE) ? {8'h00, sbyte} :
      (cmd_r == `CMD_STAT_WORD) ? ((16'(warn_r) << `SW_VOUT) | {8'h00, sbyte}) :
      (cmd_r == `CMD_STAT_VOUT) ? (16'(warn_r) << `SV_MAXMIN_WARN) :
      (cmd_r == `CMD_STAT_CML) ? (16'(ivd_r) << `SC_INVALID_DATA) : 16'h0000;
   wire [7:0] tx_next = txhi_r ? rd_word[15:8] : 8'h00;

   // Byte-level bus engine
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= ST_IDLE;
         {bitc_r, nb_r, sh_r, tx_r, cmd_r, lo_r} <= '0;
         {rw_r, half_r, drv_r, txhi_r, wr_r} <= '0;
         wadr_r <= 8'h00;
         wdat_r <= 16'h0000;
      end else if (CE) begin
         wr_r <= 1'b0;
         if (stop) begin
            st_r <= ST_IDLE;
            drv_r <= 1'b0;
         end else if (start) begin
            st_r <= ST_RX;
            bitc_r <= 3'h0;
            nb_r <= 3'h0;
            drv_r <= 1'b0;
         end else begin
            unique case (st_r)
               ST_IDLE: begin
               end
               ST_RX: if (rise) begin
                  sh_r <= {sh_r[6:0], sda_s};
                  bitc_r <= bitc_r + 3'h1;
                  half_r <= 1'b0;
                  if (bitc_r == 3'h7) st_r <= ST_AK;
               end
               ST_AK: if (fall) begin
                  if (!half_r) begin
                     half_r <= 1'b1;
                     drv_r <= ack_ok;
                     if (!ack_ok) st_r <= ST_IDLE;
                     if (nb_r == 3'h0) rw_r <= sh_r[0];
                     if (nb_r == 3'h1) cmd_r <= sh_r;
                     if (nb_r == 3'h2) lo_r <= sh_r;
                     if (nb_r != 3'h7) nb_r <= nb_r + 3'h1;
                     wr_r <= commit_w & ~rw_r;
                     wadr_r <= wadr_w;
                     wdat_r <= wdat_w;
                  end else if (rw_r) begin
                     st_r <= ST_TX;
                     tx_r <= rd_word[7:0];
                     drv_r <= ~rd_word[7];
                     bitc_r <= 3'h0;
                     txhi_r <= 1'b1;
                  end else begin
                     drv_r <= 1'b0;
                     st_r <= ST_RX;
                     bitc_r <= 3'h0;
                  end
               end
               ST_TX: if (fall) begin
                  if (bitc_r == 3'h7) begin
                     drv_r <= 1'b0;
                     st_r <= ST_MA;
                  end else begin
                     drv_r <= ~tx_r[6];
                     tx_r <= {tx_r[6:0], 1'b0};
                     bitc_r <= bitc_r + 3'h1;
                  end
               end
               ST_MA: if (rise && sda_s) begin
                  st_r <= ST_IDLE;
               end else if (fall) begin
                  st_r <= ST_TX;
                  tx_r <= tx_next;
                  drv_r <= ~tx_next[7];
                  bitc_r <= 3'h0;
                  txhi_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Write decode
   wire w_cmd = wr_r & (wadr_r == `CMD_COMMAND);
   wire w_trim = wr_r & (wadr_r == `CMD_TRIM);
   wire w_max = wr_r & (wadr_r == `CMD_UPPER_LIMIT);
   wire w_min = wr_r & (wadr_r == `CMD_LOWER_LIMIT);
   wire w_mh = wr_r & (wadr_r == `CMD_MARGIN_HIGH);
   wire w_op = wr_r & (wadr_r == `CMD_OPERATION);
   wire clr = wr_r & (wadr_r == `CMD_CLEAR_FAULTS);
   wire trim_bad = ~(&wdat_r[15:6] | ~|wdat_r[15:6]);
   wire max_bad = (wdat_r < LIMIT_LO) | (wdat_r > LIMIT_HI);
   wire mh_bad = |wdat_r[15:11];
   wire ivd_set = (w_trim & trim_bad) | (w_max & max_bad) | (w_mh & mh_bad) |
      (wr_r & (wadr_r == `CMD_MODE));
   wire signed [17:0] vmax_s = $signed({6'h00, umax_r});
   wire signed [17:0] vmin_s = $signed({6'h00, umin_r});
   wire signed [17:0] cw = $signed({5'h00, wdat_r[12:0]}) + 18'(trim_ext);
   wire cmd_hi = cw > vmax_s;
   wire cmd_lo = cw < vmin_s;
   wire vcode_t cmd_new = cmd_hi ? {1'b0, umax_r} : cmd_lo ? {1'b0, umin_r} : wdat_r[12:0];

   // Target: command plus trim plus relative margin, then clamps
   wire signed [12:0] mdelta = $signed({2'b00, mh_r}) - `MARGIN_UNITY;
   wire signed [26:0] prod = $signed({1'b0, cmd_v_r}) * mdelta;
   wire signed [17:0] mterm = op_r[`OP_MARGIN_HIGH] ? prod[26:9] : 18'sh00000;
   wire signed [17:0] raw = $signed({5'h00, cmd_v_r}) + 18'(trim_ext) + mterm;
   wire signed [17:0] dac_s = $signed({5'h00, DAC_MAX});
   // Lower limit first, so it can never lift the target past the DAC range
   wire signed [17:0] t1 = (raw < vmin_s) ? vmin_s : raw;
   wire signed [17:0] t2 = (t1 > dac_s) ? dac_s : t1;
   wire signed [17:0] t3 = (t2 > vmax_s) ? vmax_s : t2;
   wire vcode_t target_w = t3[12:0];
   wire over_w = (raw > vmax_s) | (raw < vmin_s) | (raw > dac_s);
   wire warn_set = (w_cmd & (cmd_hi | cmd_lo)) | (upd_r & over_w);

   // Register file and sticky status; a set wins over a clear
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_v_r <= `RST_COMMAND;
         trim_r <= `RST_TRIM;
         umax_r <= `RST_UPPER_LIMIT;
         umin_r <= `RST_LOWER_LIMIT;
         mh_r <= `RST_MARGIN_HIGH;
         op_r <= 8'h00;
         {warn_r, ivd_r, alert_r, upd_r} <= 4'h0;
      end else if (CE) begin
         if (w_cmd) cmd_v_r <= cmd_new;
         if (w_trim && !trim_bad) trim_r <= wdat_r[6:0];
         if (w_max && !max_bad) umax_r <= wdat_r[11:0];
         if (w_min) umin_r <= wdat_r[11:0];
         if (w_mh && !mh_bad) mh_r <= wdat_r[10:0];
         if (w_op) op_r <= wdat_r[7:0];
         upd_r <= w_cmd | w_trim | w_max | w_min | w_mh | w_op;
         warn_r <= warn_set | (warn_r & ~clr);
         ivd_r <= ivd_set | (ivd_r & ~clr);
         alert_r <= warn_set | ivd_set | ((warn_r | ivd_r) & ~clr);
      end
   end

   // Single slew-limited ramp toward the clamped target
   wire step = (cnt_r == 16'(STEP_CYC - 1));
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tgt_r <= `RST_COMMAND;
         out_r <= 13'h0000;
         cnt_r <= 16'h0000;
      end else if (CE) begin
         tgt_r <= target_w;
         cnt_r <= step ? 16'h0000 : cnt_r + 16'h0001;
         if (step && CONV_EN && out_r < tgt_r) out_r <= out_r + 13'h0001;
         if (step && CONV_EN && out_r > tgt_r) out_r <= out_r - 13'h0001;
      end
   end

   assign SDA_O = 1'b0;
   assign SDA_OE_N = ~drv_r;
   assign ALERT_O = 1'b0;
   assign ALERT_OE_N = ~alert_r;
   assign TARGET_CODE = tgt_r;
   assign VOUT_CODE = out_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_over_write;
      CE && w_cmd && (cmd_hi || cmd_lo);
   endsequence
   sequence s_raw_over;
      CE && upd_r && raw > vmax_s;
   endsequence

   AST_TARGET_UNDER_MAX: assert property (target_w <= {1'b0, umax_r})
      else $error("target above upper limit");
   AST_TARGET_UNDER_DAC: assert property (target_w <= DAC_MAX)
      else $error("target above DAC range");
   AST_MAX_WINS: assert property ((umax_r < umin_r) && ({1'b0, umax_r} <= DAC_MAX) |->
      target_w == {1'b0, umax_r})
      else $error("upper limit did not dominate");
   AST_CMD_CLAMP: assert property (s_over_write |=> (cmd_v_r == $past(cmd_new)) && warn_r)
      else $error("command write not clamped");
   AST_OVER_STATUS: assert property (s_raw_over |=> warn_r && alert_r ##1 !ALERT_OE_N)
      else $error("over-limit status missing");
   AST_TRIM_READBACK: assert property ((cmd_r == `CMD_TRIM) |-> (&rd_word[15:6] || ~|rd_word[15:6]))
      else $error("trim upper bits not sign extended");
   AST_MAX_READBACK: assert property ((cmd_r == `CMD_UPPER_LIMIT) |-> rd_word[15:12] == 4'h0)
      else $error("upper limit top bits not zero");
   AST_TRIM_INVALID: assert property (CE && w_trim && trim_bad |=> ivd_r && $stable(trim_r))
      else $error("bad trim write not flagged");
   AST_RAMP_STEP: assert property (CE |=> (out_r == $past(out_r)) ||
      (out_r == $past(out_r) + 13'h0001) || (out_r == $past(out_r) - 13'h0001))
      else $error("output stepped by more than one code");
   AST_MAX_REJECT: assert property (CE && w_max && max_bad |=> $stable(umax_r) && ivd_r)
      else $error("bad upper limit write accepted");
   // Warning, alert and ramp behaviour the bus scenarios reach only indirectly
   AST_DAC_WARN: assert property (CE && upd_r && (raw > dac_s) |=> warn_r)
      else $error("DAC overflow did not raise warning");
   AST_ALERT_HOLD: assert property (CE && (warn_r || ivd_r) && !clr |=> alert_r)
      else $error("alert dropped while a fault stands");
   AST_LIMIT_RAMP: assert property (CE && CONV_EN && step && (out_r > tgt_r) |=>
      out_r == $past(out_r) - 13'h0001)
      else $error("output did not ramp down toward the target");
   AST_HOLD_NO_CONV: assert property (CE && !CONV_EN |=> $stable(out_r))
      else $error("output moved with conversion disabled");
endmodule
`default_nettype wire

// ==== rtl/vout_target_map.svh ====
/*
 Command codes, field positions, reset values and timing counts for the output-voltage target
 logic. Included by the package and the design; holds definitions only.
*/
`ifndef VOUT_TARGET_MAP_SVH
`define VOUT_TARGET_MAP_SVH
`define CMD_OPERATION    8'h01
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_MODE         8'h20
`define CMD_COMMAND      8'h21
`define CMD_TRIM         8'h22
`define CMD_UPPER_LIMIT  8'h24
`define CMD_MARGIN_HIGH  8'h25
`define CMD_LOWER_LIMIT  8'h2b
`define CMD_STAT_BYTE    8'h78
`define CMD_STAT_WORD    8'h79
`define CMD_STAT_VOUT    8'h7a
`define CMD_STAT_CML     8'h7e
`define MODE_VALUE       8'h97
`define MARGIN_UNITY     13'sh0200
`define OP_MARGIN_HIGH   5
`define SB_NONE_ABOVE    0
`define SB_CML           1
`define SW_VOUT          15
`define SV_MAXMIN_WARN   3
`define SC_INVALID_DATA  6
`define RST_COMMAND      13'h0100
`define RST_TRIM         7'h00
`define RST_UPPER_LIMIT  12'h180
`define RST_LOWER_LIMIT  12'h000
`define RST_MARGIN_HIGH  11'h210
`define CLK_PERIOD_NS    10
`define STEP_TIME_NS     1000
`define STEP_CYCLES      (`STEP_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== rtl/vout_target_pkg.sv ====
/*
 Types for the output-voltage target logic.
 Assumes the command map header sits beside it.
*/
`include "vout_target_map.svh"
package vout_target_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_AK   = 5'b00100,
      ST_TX   = 5'b01000,
      ST_MA   = 5'b10000
   } link_state_t;
   typedef logic [12:0] vcode_t;
endpackage

// ==== verification/pmbus_host_model.sv ====
/*
 Behavioural PMBus host: start, stop, byte and word transfers on SCL/SDA.
 Assumes the caller's clock runs at 10 ns; SCL runs at 80 ns inside frames only.
*/
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model (
   input wire logic clk,
   input wire logic dev_oe_n,
   output logic scl,
   output logic sda
);
   logic host_sda;
   // Open-drain wire with pull-up
   assign sda = host_sda & dev_oe_n;
   initial begin
      scl = 1'b1;
      host_sda = 1'b1;
   end
   task automatic q;
      repeat (2) @(negedge clk);
   endtask
   task automatic start;
      host_sda = 1'b1;
      q;
      scl = 1'b1;
      q;
      host_sda = 1'b0;
      q;
      scl = 1'b0;
      q;
   endtask
   task automatic stop;
      host_sda = 1'b0;
      q;
      scl = 1'b1;
      q;
      host_sda = 1'b1;
      q;
   endtask
   task automatic bit_io(input logic b, output logic r);
      host_sda = b;
      q;
      scl = 1'b1;
      q;
      r = sda;
      q;
      scl = 1'b0;
      q;
   endtask
   // Last bit released for the slave's ack, or host ack/nack on reads
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r,
                          output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(last, a);
      ack = !a;
   endtask
   task automatic xfer(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data,
                       input int n, output logic ok);
      logic [7:0] r;
      logic a;
      start;
      byte_io({addr, 1'b0}, 1'b1, r, ok);
      byte_io(cmd, 1'b1, r, a);
      ok &= a;
      for (int i = 0; i < n; i++) begin
         byte_io(data[8*i+:8], 1'b1, r, a);
         ok &= a;
      end
      stop;
   endtask
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] v, output logic ok);
      logic [7:0] r;
      logic a;
      start;
      byte_io(8'h54, 1'b1, r, ok);
      byte_io(cmd, 1'b1, r, a);
      start;
      byte_io(8'h55, 1'b1, r, a);
      byte_io(8'hff, 1'b0, v[7:0], a);
      byte_io(8'hff, 1'b1, v[15:8], a);
      stop;
   endtask
endmodule
`default_nettype wire

// ==== verification/vout_target_limit_logic_test.sv ====
/*
 Self-checking bench for the output-voltage target logic over PMBus.
 Assumes the host model drives the bus and the design answers at DEV_ADDR 0x2a.
*/
`timescale 1ns/1ns
`default_nettype none
module vout_target_limit_logic_test;
   import vout_target_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic conv_en = 1'b1;
   logic ce = 1'b1;
   logic scl, sda, sda_o, sda_oe_n, alert_o, alert_oe_n, ok;
   vcode_t target_code, vout_code, held;
   int errors = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   vout_target_limit_logic #(.DAC_MAX(13'h0170), .STEP_CYC(2)) dut (
      .CLK(clk), .RSTN(rstn), .CE(ce), .CONV_EN(conv_en), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .ALERT_O(alert_o), .ALERT_OE_N(alert_oe_n),
      .TARGET_CODE(target_code), .VOUT_CODE(vout_code));
   pmbus_host_model host (.clk(clk), .dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
      logic a;
      host.xfer(7'h2a, cmd, d, n, a);
      check({15'h0000, a}, 16'h0001);
      repeat (4) @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] v;
      logic a;
      host.read_word(cmd, v, a);
      check({15'h0000, a}, 16'h0001);
      check(v & mask, exp);
   endtask
   // Wait for the ramp to reach the target, bounded
   task automatic settle;
      int i;
      i = 0;
      while (vout_code !== target_code && i < 2000) begin
         @(negedge clk);
         i++;
      end
      if (i == 2000) begin
         errors++;
         print_verdict;
      end
   endtask
   initial begin
      #900000;
      errors++;
      print_verdict;
   end
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      check({3'h0, target_code}, 16'h0100);
      check({14'h0000, sda_o, alert_o}, 16'h0000);
      rd(8'h20, 16'h00ff, 16'h0097);
      rd(8'h24, 16'hffff, 16'h0180);
      rd(8'h25, 16'hffff, 16'h0210);
      settle;
      check({3'h0, vout_code}, 16'h0100);
      host.xfer(7'h2b, 8'h22, 16'h0010, 2, ok);
      check({15'h0000, ok}, 16'h0000);
      wr(8'h22, 16'hffc0, 2);
      check({3'h0, target_code}, 16'h00c0);
      check({15'h0000, vout_code > 13'h00c0}, 16'h0001);
      rd(8'h22, 16'hffff, 16'hffc0);
      settle;
      check({3'h0, vout_code}, 16'h00c0);
      wr(8'h22, 16'h003f, 2);
      check({3'h0, target_code}, 16'h013f);
      wr(8'h22, 16'h0080, 2);
      rd(8'h22, 16'hffff, 16'h003f);
      wr(8'h22, 16'h0040, 2);
      rd(8'h22, 16'hffff, 16'h003f);
      rd(8'h7e, 16'h0040, 16'h0040);
      check({15'h0000, alert_oe_n}, 16'h0000);
      wr(8'h03, 16'h0000, 0);
      check({15'h0000, alert_oe_n}, 16'h0001);
      wr(8'h22, 16'h0000, 2);
      wr(8'h24, 16'h00c0, 2);
      check({3'h0, target_code}, 16'h00c0);
      rd(8'h7a, 16'h0008, 16'h0008);
      rd(8'h78, 16'h0001, 16'h0001);
      rd(8'h79, 16'h8000, 16'h8000);
      check({15'h0000, alert_oe_n}, 16'h0000);
      settle;
      check({3'h0, vout_code}, 16'h00c0);
      wr(8'h03, 16'h0000, 0);
      wr(8'h2b, 16'h0100, 2);
      check({3'h0, target_code}, 16'h00c0);
      wr(8'h2b, 16'h0000, 2);
      wr(8'h24, 16'h0064, 2);
      rd(8'h24, 16'hffff, 16'h00c0);
      rd(8'h7e, 16'h0040, 16'h0040);
      wr(8'h03, 16'h0000, 0);
      wr(8'h24, 16'h0180, 2);
      wr(8'h21, 16'h0200, 2);
      rd(8'h21, 16'hffff, 16'h0180);
      check({3'h0, target_code}, 16'h0170);
      rd(8'h7a, 16'h0008, 16'h0008);
      rd(8'h79, 16'h8000, 16'h8000);
      check({15'h0000, alert_oe_n}, 16'h0000);
      wr(8'h03, 16'h0000, 0);
      wr(8'h21, 16'h0178, 2);
      rd(8'h21, 16'hffff, 16'h0178);
      check({3'h0, target_code}, 16'h0170);
      rd(8'h7a, 16'h0008, 16'h0008);
      wr(8'h03, 16'h0000, 0);
      wr(8'h21, 16'h0100, 2);
      settle;
      wr(8'h25, 16'h0240, 2);
      rd(8'h25, 16'hffff, 16'h0240);
      wr(8'h01, 16'h0020, 1);
      check({3'h0, target_code}, 16'h0120);
      check({15'h0000, vout_code < 13'h0120}, 16'h0001);
      settle;
      wr(8'h22, 16'h0004, 2);
      check({3'h0, target_code}, 16'h0124);
      conv_en = 1'b0;
      wr(8'h01, 16'h0000, 1);
      held = vout_code;
      repeat (20) @(negedge clk);
      check({3'h0, vout_code}, {3'h0, held});
      conv_en = 1'b1;
      ce = 1'b0;
      held = vout_code;
      repeat (10) @(negedge clk);
      check({3'h0, vout_code}, {3'h0, held});
      ce = 1'b1;
      settle;
      check({3'h0, vout_code}, 16'h0104);
      print_verdict;
   end
endmodule
`default_nettype wire
